/* File: epi_pkg.sv */
// constants, register map and carrier types of the encoder emulation block
`default_nettype none
package epi_pkg;
	// clock and timing
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned EDGE_SPACING_NS = 200;
	localparam int unsigned EDGE_CYC_I = (EDGE_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] EDGE_CYC = 4'(EDGE_CYC_I);
	localparam int unsigned SSI_PERIOD_NS = 600;
	localparam int unsigned SSI_HALF_I = SSI_PERIOD_NS / 2 / CLK_PERIOD_NS;
	localparam logic [4:0] SSI_HALF_CYC = 5'(SSI_HALF_I);
	localparam int unsigned TOUT_SHORT_NS = 3000;
	localparam int unsigned TOUT_LONG_NS = 13000;
	localparam logic [9:0] TOUT_SHORT_CYC =
		10'((TOUT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] TOUT_LONG_CYC =
		10'((TOUT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LINES = 8'h04;
	localparam logic [7:0] ADDR_OFFSET = 8'h08;
	localparam logic [7:0] ADDR_GEAR = 8'h0c;
	localparam logic [7:0] ADDR_FBPOS = 8'h10;
	localparam logic [7:0] ADDR_COUNT = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// emulation_select codes
	localparam logic [2:0] EMU_OFF = 3'h0;
	localparam logic [2:0] EMU_QUAD = 3'h1;
	localparam logic [2:0] EMU_SSI = 3'h2;
	localparam logic [2:0] EMU_INTERP = 3'h3;
	// gearing_input_select codes
	localparam logic [2:0] GEAR_QUAD = 3'h3;
	localparam logic [2:0] GEAR_STEP = 3'h4;
	localparam logic [2:0] GEAR_SSI = 3'h5;
	// feedback_type_select codes
	localparam logic [7:0] FB_RESOLVER = 8'h00;
	localparam logic [7:0] FB_SSI = 8'h09;
	localparam logic [7:0] FB_HALL = 8'h12;
	// line count limits
	localparam logic [19:0] LINES_RES_MIN = 20'h00020;
	localparam logic [19:0] LINES_RES_MAX = 20'h01000;
	localparam logic [19:0] LINES_ENC_MIN = 20'h00100;
	localparam logic [19:0] LINES_ENC_MAX = 20'h80000;
	localparam logic [19:0] LINES_SAFE_MAX = 20'h01000;
	localparam logic [19:0] LINES_RESET = 20'h00400;
	// turn count width limits and field sizes
	localparam logic [4:0] TURN_W_MIN = 5'h0c;
	localparam logic [4:0] TURN_W_MAX = 5'h10;
	localparam logic [5:0] ANGLE_W = 6'h10;
	localparam logic [5:0] WORD_W = 6'h20;
	localparam logic [3:0] INTERP_BASE = 4'h4;
	localparam logic [21:0] QUAD_INDEX_POS = 22'h000002;
	// control register layout, low bit last
	typedef struct packed {
		logic rev_dir;
		logic [1:0] interp_shift;
		logic [4:0] turn_count_width;
		logic encoder_supply_enable;
		logic frame_timeout_select;
		logic fb_gray;
		logic emu_gray;
		logic [7:0] feedback_type_select;
		logic [2:0] gearing_input_select;
		logic [2:0] emulation_select;
	} epi_ctrl_s;
	localparam epi_ctrl_s CTRL_RESET = '{
		rev_dir: 1'b0, interp_shift: 2'h0, turn_count_width: TURN_W_MIN,
		encoder_supply_enable: 1'b0, frame_timeout_select: 1'b0,
		fb_gray: 1'b0, emu_gray: 1'b0, feedback_type_select: FB_RESOLVER,
		gearing_input_select: 3'h0, emulation_select: EMU_OFF};
	// connector inputs, sampled together
	typedef struct packed {
		logic enc_a;
		logic enc_b;
		logic enc_idx;
		logic [2:0] hall;
		logic ssi_clk;
		logic fb_data;
		logic step;
		logic dir;
		logic safety_card;
	} epi_pins_s;
endpackage
`default_nettype wire

/* File: epi_top.sv */
// encoder emulation, serial position output and position inputs with wishbone registers
//
// Behaviour
// [RULE1] quadrature pair plus index from shaft position
// [RULE2] index once per turn, only at A=B=1
// [RULE3] line count range checked per feedback type
// [RULE4] interpolation multiplies input counts, passes index
// [RULE5] safety card: binary resolutions up to 4096
// [RULE6] index offset shifts index within one turn
// [RULE7] clockwise rotation counts up by default
// [RULE8] serial frame at most 32 bits
// [RULE9] turn count sent first, 12 to 16 bits
// [RULE10] then fixed 16-bit position within turn
// [RULE11] serial word gray or binary, binary default
// [RULE12] reader clock 600 ns, timeout 3/13 us
// [RULE13] received serial word decoded gray or binary
// [RULE14] hall gives commutation, encoder gives fine position
// [RULE15] master output fans out to 16 slaves
// [RULE16] quad 1 with gear 3, serial 2 with 5
// [RULE17] gearing 4 takes step and direction pulses
// [RULE18] encoder supply only when enable is 1
// [RULE19] frame latches position at first clock edge
// [RULE20] phase order reverses with shaft direction
`default_nettype none
module epi_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [15:0] shaft_angle_i,
	input wire logic [15:0] shaft_turns_i,
	input wire epi_pkg::epi_pins_s pins_i,
	output logic quad_a_o,
	output logic quad_b_o,
	output logic index_pulse_o,
	output logic ssi_data_o,
	output logic fb_clk_o,
	output logic encoder_supply_o,
	output logic [2:0] comm_sector_o,
	output logic [31:0] gear_position_o
);
	// serial emulation states
	typedef enum logic [1:0] {
		SE_IDLE = 2'b00,
		SE_SHIFT = 2'b01,
		SE_WAIT = 2'b10
	} epi_se_e;
	// serial reader states
	typedef enum logic [1:0] {
		SR_IDLE = 2'b00,
		SR_CLK = 2'b01,
		SR_WAIT = 2'b10
	} epi_sr_e;

	epi_pkg::epi_ctrl_s ctrl; // control register
	logic [19:0] lines; // emulated_line_count
	logic [15:0] index_position_offset; // angle units
	epi_pkg::epi_pins_s sync1; // first stage, read only by pins
	epi_pkg::epi_pins_s pins; // synchronised pins
	epi_pkg::epi_pins_s pins_q; // previous sample for edges
	logic [21:0] rev_pos; // emitted quarter steps
	logic [21:0] des_int; // interpolation target
	logic [3:0] space_cnt; // edge spacing timer
	logic [31:0] fb_count; // input quadrature count
	logic [31:0] step_count; // step/direction count
	logic [31:0] fb_pos; // decoded serial feedback
	epi_se_e se_state;
	logic [31:0] se_shift; // left-justified frame
	logic [5:0] se_bits; // bits still to send
	logic [9:0] se_timer;
	epi_sr_e sr_state;
	logic [4:0] sr_half;
	logic [5:0] sr_bits;
	logic [31:0] sr_shift;
	logic [9:0] sr_timer;

	// merge write data by byte enables
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction

	// gray to binary, msb downward
	function automatic logic [31:0] gray2bin(input logic [31:0] g);
		logic [31:0] b;
		b = g;
		for (int i = 30; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	// legal line count for the present feedback and card
	function automatic logic lines_ok(input logic [19:0] v, input logic [7:0] fb,
		input logic safe);
		logic pow2;
		logic in_range;
		pow2 = (v != 20'h0) && ((v & (v - 20'h1)) == 20'h0);
		if (fb == epi_pkg::FB_RESOLVER)
			in_range = (v >= epi_pkg::LINES_RES_MIN) && (v <= epi_pkg::LINES_RES_MAX); // [RULE3]
		else
			in_range = pow2 && (v >= epi_pkg::LINES_ENC_MIN)
				&& (v <= epi_pkg::LINES_ENC_MAX); // [RULE3]
		if (safe)
			in_range = in_range && pow2 && (v <= epi_pkg::LINES_SAFE_MAX); // [RULE5]
		return in_range;
	endfunction

	logic wb_req; // a fresh bus cycle
	logic [31:0] wr_data;
	logic [31:0] ctrl_word;
	logic [31:0] next_ctrl_word;
	logic [19:0] next_lines;
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign ctrl_word = {6'h0, ctrl};

	// combine old and new contents by lanes
	always_comb
	begin
		next_ctrl_word = merge(ctrl_word, wb_dat_i, wb_sel_i);
		wr_data = merge({12'h0, lines}, wb_dat_i, wb_sel_i);
		next_lines = wr_data[19:0];
	end

	// two-flop pin synchroniser and edge history
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1 <= '0;
			pins <= '0;
			pins_q <= '0;
		end
		else
		begin
			sync1 <= pins_i;
			pins <= sync1;
			pins_q <= pins;
		end
	end

	// bus acknowledge, one cycle per request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	// control register; a write with an illegal turn width is dropped whole
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl <= epi_pkg::CTRL_RESET;
		else if (wb_req && wb_we_i && wb_adr_i == epi_pkg::ADDR_CTRL)
		begin
			if (next_ctrl_word[22:18] >= epi_pkg::TURN_W_MIN
				&& next_ctrl_word[22:18] <= epi_pkg::TURN_W_MAX) // [RULE9]
				ctrl <= epi_pkg::epi_ctrl_s'(next_ctrl_word[25:0]);
		end
	end

	// line count; a value outside the legal set is dropped
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lines <= epi_pkg::LINES_RESET;
		else if (wb_req && wb_we_i && wb_adr_i == epi_pkg::ADDR_LINES)
		begin
			if (lines_ok(next_lines, ctrl.feedback_type_select, pins.safety_card)) // [RULE3]
				lines <= next_lines;
		end
	end

	// index offset register, kept until rewritten
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			index_position_offset <= 16'h0;
		else if (wb_req && wb_we_i && wb_adr_i == epi_pkg::ADDR_OFFSET)
			index_position_offset <= 16'(merge({16'h0, index_position_offset},
				wb_dat_i, wb_sel_i)); // [RULE6]
	end

	// read mux; unmapped addresses read zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0;
		else if (wb_req && !wb_we_i)
		begin
			unique case (wb_adr_i)
				epi_pkg::ADDR_CTRL: wb_dat_o <= ctrl_word;
				epi_pkg::ADDR_LINES: wb_dat_o <= {12'h0, lines};
				epi_pkg::ADDR_OFFSET: wb_dat_o <= {16'h0, index_position_offset};
				epi_pkg::ADDR_GEAR: wb_dat_o <= gear_position_o;
				epi_pkg::ADDR_FBPOS: wb_dat_o <= fb_pos;
				epi_pkg::ADDR_COUNT: wb_dat_o <= fb_count;
				epi_pkg::ADDR_STATUS: wb_dat_o <= {24'h0, pins.safety_card,
					se_state, sr_state, index_pulse_o, quad_b_o, quad_a_o};
				default: wb_dat_o <= 32'h0;
			endcase
		end
	end

	// input quadrature decode
	logic q_move;
	logic q_up;
	assign q_move = (pins.enc_a ^ pins_q.enc_a) ^ (pins.enc_b ^ pins_q.enc_b);
	assign q_up = pins.enc_a ^ pins_q.enc_b;

	// fine position count from the input encoder
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fb_count <= 32'h0;
		else if (q_move)
			fb_count <= q_up ? fb_count + 32'h1 : fb_count - 32'h1; // [RULE14]
	end

	// commutation straight from the hall sensors
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			comm_sector_o <= 3'h0;
		else if (ctrl.feedback_type_select == epi_pkg::FB_HALL)
			comm_sector_o <= pins.hall; // [RULE14]
	end

	// step/direction count on step rising edges
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			step_count <= 32'h0;
		else if (pins.step && !pins_q.step)
			step_count <= pins.dir ? step_count - 32'h1 : step_count + 32'h1; // [RULE17]
	end

	// gearing source select
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			gear_position_o <= 32'h0;
		else
		begin
			unique case (ctrl.gearing_input_select)
				epi_pkg::GEAR_QUAD: gear_position_o <= fb_count; // [RULE16]
				epi_pkg::GEAR_STEP: gear_position_o <= step_count; // [RULE17]
				epi_pkg::GEAR_SSI: gear_position_o <= fb_pos; // [RULE16]
				default: gear_position_o <= 32'h0;
			endcase
		end
	end

	// quadrature target from shaft angle, shifted by the index offset
	logic [15:0] rel_angle;
	logic [21:0] lines4;
	logic [37:0] prod;
	logic [21:0] des_quad;
	logic signed [22:0] diff;
	logic is_quad;
	logic is_interp;
	assign rel_angle = shaft_angle_i - index_position_offset; // [RULE6]
	assign lines4 = {lines, 2'b00};
	assign prod = 38'(rel_angle) * 38'(lines4);
	assign des_quad = prod[37:16]; // [RULE1]
	assign is_quad = ctrl.emulation_select == epi_pkg::EMU_QUAD; // [RULE16]
	assign is_interp = ctrl.emulation_select == epi_pkg::EMU_INTERP;

	// shortest way round the turn to the target, plain difference when interpolating
	always_comb
	begin
		if (is_interp)
			diff = 23'(signed'(des_int - rev_pos));
		else
		begin
			diff = signed'({1'b0, des_quad}) - signed'({1'b0, rev_pos});
			if (diff > signed'({2'b00, lines, 1'b0}))
				diff = diff - signed'({1'b0, lines4});
			else if (diff < -signed'({2'b00, lines, 1'b0}))
				diff = diff + signed'({1'b0, lines4});
		end
	end

	// interpolated target moves 2^(4..7) steps per input step
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			des_int <= 22'h0;
		else if (!is_interp)
			des_int <= rev_pos;
		else if (q_move)
		begin
			if (q_up)
				des_int <= des_int + (22'h1 << (epi_pkg::INTERP_BASE + ctrl.interp_shift)); // [RULE4]
			else
				des_int <= des_int - (22'h1 << (epi_pkg::INTERP_BASE + ctrl.interp_shift)); // [RULE4]
		end
	end

	// edge stepper; spacing keeps edges at least 200 ns apart
	logic step_go;
	assign step_go = (is_quad || is_interp) && space_cnt == 4'h0 && diff != 23'sh0;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rev_pos <= 22'h0;
			space_cnt <= 4'h0;
		end
		else if (step_go)
		begin
			space_cnt <= epi_pkg::EDGE_CYC - 4'h1;
			if (diff > 23'sh0) // [RULE7]
				rev_pos <= (is_quad && rev_pos == lines4 - 22'h1) ? 22'h0 : rev_pos + 22'h1;
			else
				rev_pos <= (is_quad && rev_pos == 22'h0) ? lines4 - 22'h1 : rev_pos - 22'h1;
		end
		else if (space_cnt != 4'h0)
			space_cnt <= space_cnt - 4'h1;
	end

	// gray phase out; running backward reverses the phase order
	logic ph_a;
	logic ph_b;
	assign ph_a = rev_pos[1] ^ rev_pos[0]; // [RULE20]
	assign ph_b = rev_pos[1]; // [RULE1]
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			quad_a_o <= 1'b0;
			quad_b_o <= 1'b0;
			index_pulse_o <= 1'b0;
		end
		else
		begin
			// one flop per line so the fan-out to slaves sees clean edges
			quad_a_o <= ctrl.rev_dir ? ph_b : ph_a; // [RULE15]
			quad_b_o <= ctrl.rev_dir ? ph_a : ph_b; // [RULE15]
			if (is_interp)
				index_pulse_o <= pins.enc_idx; // [RULE4]
			else
				index_pulse_o <= is_quad && rev_pos == epi_pkg::QUAD_INDEX_POS; // [RULE2]
		end
	end

	// serial frame build: turns first, then 16-bit angle
	logic [4:0] tw;
	logic [5:0] frame_bits;
	logic [31:0] turns_m;
	logic [31:0] frame_raw;
	logic [31:0] frame_enc;
	logic [9:0] tout_cyc;
	assign tw = ctrl.turn_count_width;
	assign frame_bits = 6'(tw) + epi_pkg::ANGLE_W; // [RULE8]
	assign turns_m = {16'h0, shaft_turns_i} & ((32'h1 << tw) - 32'h1); // [RULE9]
	assign frame_raw = (turns_m << epi_pkg::ANGLE_W) | {16'h0, shaft_angle_i}; // [RULE10]
	assign frame_enc = ctrl.emu_gray ? (frame_raw ^ (frame_raw >> 1)) : frame_raw; // [RULE11]
	assign tout_cyc = ctrl.frame_timeout_select ? epi_pkg::TOUT_LONG_CYC
		: epi_pkg::TOUT_SHORT_CYC; // [RULE12]

	// reader clock edges
	logic sclk_fall;
	logic sclk_rise;
	assign sclk_fall = !pins.ssi_clk && pins_q.ssi_clk;
	assign sclk_rise = pins.ssi_clk && !pins_q.ssi_clk;

	// serial emulation: latch at first fall, shift on rises, hold low to timeout
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			se_state <= SE_IDLE;
			se_shift <= 32'h0;
			se_bits <= 6'h0;
			se_timer <= 10'h0;
			ssi_data_o <= 1'b1;
		end
		else if (ctrl.emulation_select != epi_pkg::EMU_SSI)
		begin
			se_state <= SE_IDLE;
			ssi_data_o <= 1'b1;
		end
		else
		begin
			unique case (se_state)
				SE_IDLE:
				begin
					ssi_data_o <= 1'b1;
					if (sclk_fall)
					begin
						// one sample for the whole frame
						se_shift <= frame_enc << (epi_pkg::WORD_W - frame_bits); // [RULE19]
						se_bits <= frame_bits;
						se_timer <= 10'h0;
						se_state <= SE_SHIFT;
					end
				end
				SE_SHIFT:
				begin
					if (sclk_rise || sclk_fall)
						se_timer <= 10'h0;
					else
						se_timer <= se_timer + 10'h1;
					if (sclk_rise)
					begin
						if (se_bits != 6'h0)
						begin
							ssi_data_o <= se_shift[31];
							se_shift <= se_shift << 1;
							se_bits <= se_bits - 6'h1;
						end
						else
						begin
							ssi_data_o <= 1'b0;
							se_state <= SE_WAIT;
						end
					end
					else if (se_timer >= tout_cyc) // reader gave up mid-frame
					begin
						ssi_data_o <= 1'b1;
						se_state <= SE_IDLE;
					end
				end
				SE_WAIT:
				begin
					// extra clocks only restart the timeout, no new frame
					if (sclk_rise || sclk_fall)
						se_timer <= 10'h0;
					else if (se_timer >= tout_cyc) // [RULE12]
					begin
						ssi_data_o <= 1'b1;
						se_state <= SE_IDLE;
					end
					else
						se_timer <= se_timer + 10'h1;
				end
				default:
					se_state <= SE_IDLE;
			endcase
		end
	end

	// serial reader for an absolute encoder; repeats frames, one timeout apart
	logic sr_en;
	assign sr_en = ctrl.feedback_type_select == epi_pkg::FB_SSI
		|| ctrl.gearing_input_select == epi_pkg::GEAR_SSI;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sr_state <= SR_IDLE;
			sr_half <= 5'h0;
			sr_bits <= 6'h0;
			sr_shift <= 32'h0;
			sr_timer <= 10'h0;
			fb_clk_o <= 1'b1;
			fb_pos <= 32'h0;
		end
		else
		begin
			unique case (sr_state)
				SR_IDLE:
				begin
					fb_clk_o <= 1'b1;
					if (sr_en && ctrl.encoder_supply_enable)
					begin
						fb_clk_o <= 1'b0;
						sr_half <= epi_pkg::SSI_HALF_CYC - 5'h1;
						sr_bits <= frame_bits;
						sr_shift <= 32'h0;
						sr_state <= SR_CLK;
					end
				end
				SR_CLK:
				begin
					if (sr_half != 5'h0)
						sr_half <= sr_half - 5'h1;
					else
					begin
						// 300 ns half period, sampled just before each fall
						sr_half <= epi_pkg::SSI_HALF_CYC - 5'h1; // [RULE12]
						if (fb_clk_o)
						begin
							sr_shift <= {sr_shift[30:0], pins.fb_data};
							sr_bits <= sr_bits - 6'h1;
							if (sr_bits == 6'h1)
							begin
								sr_timer <= 10'h0;
								sr_state <= SR_WAIT;
							end
							else
								fb_clk_o <= 1'b0;
						end
						else
							fb_clk_o <= 1'b1;
					end
				end
				SR_WAIT:
				begin
					if (sr_timer >= tout_cyc)
					begin
						fb_pos <= ctrl.fb_gray ? gray2bin(sr_shift) : sr_shift; // [RULE13]
						sr_state <= SR_IDLE;
					end
					else
						sr_timer <= sr_timer + 10'h1;
				end
				default:
					sr_state <= SR_IDLE;
			endcase
		end
	end

	// external encoder supply follows the enable bit only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			encoder_supply_o <= 1'b0;
		else
			encoder_supply_o <= ctrl.encoder_supply_enable; // [RULE18]
	end
endmodule
`default_nettype wire

/* File: epi_checker.sv */
// assertion checker for the encoder emulation block, bound to its top
`default_nettype none
module epi_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire epi_pkg::epi_pins_s pins_i,
	input wire logic quad_a_o,
	input wire logic quad_b_o,
	input wire logic index_pulse_o,
	input wire logic ssi_data_o,
	input wire logic fb_clk_o,
	input wire logic encoder_supply_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	epi_pkg::epi_ctrl_s sh; // shadow of accepted control words
	logic req; // open request
	logic ctrl_ok; // control write that the block keeps
	logic last_sc; // reader clock one cycle ago
	logic [9:0] quiet;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// the shadow drops whole writes with bad turn widths too
	assign ctrl_ok = wb_ack_o && wb_we_i && wb_adr_i == epi_pkg::ADDR_CTRL
		&& wb_dat_i[22:18] >= epi_pkg::TURN_W_MIN && wb_dat_i[22:18] <= epi_pkg::TURN_W_MAX;
	// control shadow
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sh <= epi_pkg::CTRL_RESET;
		else if (ctrl_ok)
			sh <= wb_dat_i[25:0];
	end
	// quiet timer on the raw pin, ahead of the block
	always_ff @(posedge clk_i)
	begin
		last_sc <= pins_i.ssi_clk;
		if (rst_i || pins_i.ssi_clk != last_sc)
			quiet <= 10'h000;
		else if (quiet != 10'h3ff)
			quiet <= quiet + 10'h001;
	end
	a_ack_answers: assert property (req |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 8'h1c |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_index_at_ab: assert property (
		sh.emulation_select == epi_pkg::EMU_QUAD && index_pulse_o |-> quad_a_o && quad_b_o)
		else $error("index outside A=B=1");
	a_quad_one_edge: assert property (!($changed(quad_a_o) && $changed(quad_b_o)))
		else $error("both quadrature lines moved together");
	a_quad_hold: assert property (
		$changed({quad_a_o, quad_b_o}) |=> $stable({quad_a_o, quad_b_o})[*7])
		else $error("quadrature edges closer than 8 cycles");
	a_supply_follows: assert property (
		ctrl_ok |=> ##1 encoder_supply_o == sh.encoder_supply_enable)
		else $error("supply output not following its enable");
	a_ssi_idle_high: assert property (quiet > 10'h212 |-> ssi_data_o)
		else $error("serial data not idle after timeout");
	a_fb_clk_low: assert property ($fell(fb_clk_o) |-> !fb_clk_o[*8])
		else $error("encoder clock low phase too short");
endmodule
bind epi_top epi_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .pins_i, .quad_a_o, .quad_b_o, .index_pulse_o,
	.ssi_data_o, .fb_clk_o, .encoder_supply_o);
`default_nettype wire

/* File: epi_ssi_reader.sv */
// serial position reader that clocks frames out of the emulation output
`default_nettype none
module epi_ssi_reader (
	input wire logic start_i,
	input wire logic [5:0] nbits_i,
	input wire logic data_i,
	output logic sclk_o,
	output logic [31:0] word_o,
	output logic done_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// clock stands high between frames
	initial
	begin
		sclk_o = 1'b1;
		word_o = 32'h0;
		done_o = 1'b0;
	end
	// fall latches, rise shifts, sample before the rise
	always @(posedge start_i)
	begin
		#7;
		word_o = 32'h0;
		for (int k = 0; k <= int'(nbits_i); k++)
		begin
			sclk_o = 1'b0;
			#95; // 200 ns reader period
			if (k > 0)
				word_o = {word_o[30:0], data_i};
			#5;
			sclk_o = 1'b1;
			#100;
		end
		done_o = 1'b1;
		#50;
		done_o = 1'b0;
	end
endmodule
`default_nettype wire

/* File: test_epi_top.sv */
// self-checking bench for the encoder emulation block
`default_nettype none
module test_epi_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, rst_i, cyc, stb, we, ack, step, dir, fb_data, safe;
	logic qa, qb, qi, sdat, fbclk, sup, sclk, start, done;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, gear, word, s;
	logic [15:0] angle, turns;
	logic [2:0] hall, comm;
	logic [5:0] nbits;
	logic [39:0] e;
	epi_pkg::epi_pins_s pins;
	epi_pkg::epi_ctrl_s c;
	int err_count, n_tests, seed;
	logic [39:0] rd_q[$]; // expected reads, address and value
	logic [31:0] ssi_q[$]; // expected serial words
	// lines written, lines read back
	logic [19:0] t_w[10] = '{20'h00020, 20'h0001f, 20'h01000, 20'h01001, 20'h0012c,
		20'h80000, 20'h02000, 20'h00800, 20'h00030, 20'h00020};
	logic [19:0] t_e[10] = '{20'h00020, 20'h00020, 20'h01000, 20'h01000, 20'h01000,
		20'h80000, 20'h80000, 20'h00800, 20'h00800, 20'h00020};
	logic [9:0] t_enc = 10'h0f0;
	logic [9:0] t_saf = 10'h1c0;
	assign pins = '{enc_a: 1'b0, enc_b: 1'b0, enc_idx: 1'b0, hall: hall, ssi_clk: sclk,
		fb_data: fb_data, step: step, dir: dir, safety_card: safe};
	epi_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.shaft_angle_i(angle), .shaft_turns_i(turns), .pins_i(pins), .quad_a_o(qa),
		.quad_b_o(qb), .index_pulse_o(qi), .ssi_data_o(sdat), .fb_clk_o(fbclk),
		.encoder_supply_o(sup), .comm_sector_o(comm), .gear_position_o(gear));
	epi_ssi_reader u_rdr (.start_i(start), .nbits_i(nbits), .data_i(sdat), .sclk_o(sclk),
		.word_o(word), .done_o(done));
	// 40 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic check(input string what, input logic [31:0] x, input logic [31:0] got);
		n_tests++;
		if (got !== x)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, x, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// classic cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		do
		begin
			@(posedge clk_i);
			i++;
		end while (ack !== 1'b1 && i < 50);
		if (i >= 50)
		begin
			err_count++;
			conclude();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		rd_q.push_back({a, x});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	// expected serial word
	function automatic logic [31:0] ssi_exp(input logic [4:0] w, input logic g);
		logic [31:0] v;
		v = ((32'(turns) & ((32'h1 << w) - 32'h1)) << 16) | 32'(angle);
		return g ? v ^ (v >> 1) : v;
	endfunction
	// reads judged at the ack edge
	always @(posedge clk_i)
	begin
		if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
		begin
			e = rd_q.pop_front();
			check($sformatf("reg %h", e[39:32]), e[31:0], rdat);
		end
	end
	// serial frames judged when the reader finishes
	always @(posedge done)
	begin
		s = ssi_q.size() > 0 ? ssi_q.pop_front() : 32'hxxxxxxxx;
		check("ssi word", s, word);
	end
	initial
	begin
		seed = 32'he9896b59;
		{rst_i, fb_data} = 2'b11;
		{cyc, stb, we, step, dir, safe, start} = 7'h0;
		{adr, wdat, angle, turns, hall, nbits} = '0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(epi_pkg::ADDR_CTRL, 32'(epi_pkg::CTRL_RESET));
		rd(epi_pkg::ADDR_LINES, 32'(epi_pkg::LINES_RESET));
		rd(8'h1c, 32'h0);
		c = epi_pkg::CTRL_RESET;
		c.turn_count_width = 5'h11;
		wr(epi_pkg::ADDR_CTRL, 32'(c));
		rd(epi_pkg::ADDR_CTRL, 32'(epi_pkg::CTRL_RESET));
		$display("test reset done");
		for (int k = 0; k < 10; k++)
		begin
			c = epi_pkg::CTRL_RESET;
			c.feedback_type_select = t_enc[k] ? epi_pkg::FB_SSI : epi_pkg::FB_RESOLVER;
			safe <= t_saf[k];
			wr(epi_pkg::ADDR_CTRL, 32'(c));
			wr(epi_pkg::ADDR_LINES, 32'(t_w[k]));
			rd(epi_pkg::ADDR_LINES, 32'(t_e[k]));
		end
		$display("test lines done");
		// 32 lines: angle 0x0400 is quarter state 2, 0xfe00 is one step back
		c = epi_pkg::CTRL_RESET;
		c.emulation_select = epi_pkg::EMU_QUAD;
		wr(epi_pkg::ADDR_CTRL, 32'(c));
		angle <= 16'h0400;
		repeat (40) @(posedge clk_i);
		check("a b index", 32'h7, 32'({qa, qb, qi}));
		wr(epi_pkg::ADDR_OFFSET, 32'h0400);
		repeat (40) @(posedge clk_i);
		check("a b index", 32'h0, 32'({qa, qb, qi}));
		wr(epi_pkg::ADDR_OFFSET, 32'h0);
		angle <= 16'hfe00;
		repeat (40) @(posedge clk_i);
		check("a b index", 32'h2, 32'({qa, qb, qi}));
		$display("test quad done");
		for (int k = 0; k < 4; k++)
		begin
			c = epi_pkg::CTRL_RESET;
			c.emulation_select = epi_pkg::EMU_SSI;
			c.turn_count_width = k[0] ? 5'h10 : 5'h0c;
			c.emu_gray = k[1];
			c.frame_timeout_select = k[1];
			wr(epi_pkg::ADDR_CTRL, 32'(c));
			angle <= 16'($random(seed));
			turns <= 16'($random(seed));
			nbits <= 6'(c.turn_count_width) + 6'h10;
			@(posedge clk_i);
			ssi_q.push_back(ssi_exp(c.turn_count_width, k[1]));
			start <= 1'b1;
			repeat (8) @(posedge clk_i);
			start <= 1'b0;
			// frame keeps its first sample
			angle <= ~angle;
			turns <= ~turns;
			for (int i = 0; done !== 1'b1; i++)
			begin
				if (i > 2000)
				begin
					err_count++;
					conclude();
				end
				@(posedge clk_i);
			end
			repeat (k[1] ? 560 : 160) @(posedge clk_i);
		end
		$display("test ssi out done");
		c = epi_pkg::CTRL_RESET;
		c.gearing_input_select = epi_pkg::GEAR_STEP;
		wr(epi_pkg::ADDR_CTRL, 32'(c));
		for (int k = 0; k < 7; k++)
		begin
			dir <= (k > 4);
			repeat (4) @(posedge clk_i);
			step <= 1'b1;
			repeat (4) @(posedge clk_i);
			step <= 1'b0;
		end
		repeat (8) @(posedge clk_i);
		check("gear", 32'h3, gear);
		rd(epi_pkg::ADDR_GEAR, 32'h3);
		c = epi_pkg::CTRL_RESET;
		c.feedback_type_select = epi_pkg::FB_HALL;
		wr(epi_pkg::ADDR_CTRL, 32'(c));
		repeat (3)
		begin
			hall <= 3'($random(seed));
			repeat (8) @(posedge clk_i);
			check("comm", 32'(hall), 32'(comm));
		end
		$display("test step hall done");
		// data line high: all ones, then gray
		c = epi_pkg::CTRL_RESET;
		c.feedback_type_select = epi_pkg::FB_SSI;
		c.encoder_supply_enable = 1'b1;
		wr(epi_pkg::ADDR_CTRL, 32'(c));
		repeat (2) @(posedge clk_i);
		check("supply", 32'h1, 32'(sup));
		repeat (1000) @(posedge clk_i);
		rd(epi_pkg::ADDR_FBPOS, 32'h0fffffff);
		c.fb_gray = 1'b1;
		wr(epi_pkg::ADDR_CTRL, 32'(c));
		repeat (1000) @(posedge clk_i);
		rd(epi_pkg::ADDR_FBPOS, 32'h0aaaaaaa);
		$display("test ssi in done");
		conclude();
	end
endmodule
`default_nettype wire
